// *** bench/odio_host_model.sv ***
// host side model: option port index and condition lines
module odio_host_model
   import odio_pkg::*;
(
   input  wire logic       i_clk,     // system clock
   input  wire odio_cond_t i_set,     // conditions the bench asks for
   output odio_cond_t      o_cond,    // conditions seen by the module
   output logic [1:0]      o_port_sel // option port index
);
   timeunit 1ns;
   timeprecision 1ps;
   // the single i/o module always sits in slot seven, port index 0
   assign o_port_sel = 2'h0;
   // host updates its words on its own clock, never mid-cycle
   always @(posedge i_clk) o_cond <= #1 i_set;
endmodule

// *** bench/odio_top_monitor.sv ***
// port-level assertions for the digital option module
module odio_top_monitor
   import odio_pkg::*;
(
   input  wire logic        i_clk,      // system clock
   input  wire logic        i_resetn,   // async reset, active low
   input  wire logic [1:0]  i_port_sel, // option port index
   input  wire odio_req_t   i_req,      // parameter access
   input  wire logic        i_rd,       // read strobe
   input  wire logic [3:0]  i_ac_in,    // line inputs
   input  wire logic [15:0] o_rdata,    // read data
   input  wire logic        o_rvalid,   // read valid
   input  wire logic [7:0]  o_status,   // status word
   input  wire logic [3:0]  o_fn_act,   // active inputs
   input  wire logic [2:0]  o_relay,    // relay coils
   input  wire logic [1:0]  o_port     // held port
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   chk_ready_after_rst: assert property ($past(i_resetn) && $past(i_resetn, 2)
      && $past(i_resetn, 3) |-> o_status[ST_READY_BIT]) else $error("ready bit low");
   // input bits pass two flops before they show in the status word
   chk_input_mirror: assert property ($past(i_resetn) && $past(i_resetn, 2)
      |-> o_status[4:1] == $past(i_ac_in, 2))
      else $error("status input bits wrong");
   chk_relay_mirror: assert property ($stable(o_relay)[*4] |-> o_status[7:5] == o_relay)
      else $error("status relay bits wrong");
   chk_port_held: assert property ($past(i_resetn) |-> o_port == $past(i_port_sel))
      else $error("port copy wrong");
   chk_read_answer: assert property (i_rd |=> o_rvalid)
      else $error("read not answered");
   chk_read_quiet: assert property (!i_rd |=> !o_rvalid)
      else $error("spurious read valid");
   chk_unmapped_zero: assert property (i_rd && (i_req.addr == 8'h00 || i_req.addr > PARAM_MGMT)
      |=> o_rdata == 16'h0000) else $error("unmapped read not zero");
   chk_idle_inputs: assert property ((i_ac_in == 4'h0)[*3] |=> o_fn_act == 4'h0)
      else $error("function active without input");
   chk_restore_drop: assert property (i_req.wr && i_req.addr == PARAM_MGMT
      && i_req.wdata[7:0] == MGMT_FACTORY |-> ##[1:3] o_relay == 3'h0)
      else $error("relays kept after restore");
endmodule
bind odio_top odio_top_monitor u_odio_top_monitor (.i_clk(i_clk), .i_resetn(i_resetn),
   .i_port_sel(i_port_sel), .i_req(i_req), .i_rd(i_rd), .i_ac_in(i_ac_in), .o_rdata(o_rdata),
   .o_rvalid(o_rvalid), .o_status(o_status), .o_fn_act(o_fn_act), .o_relay(o_relay),
   .o_port(o_port));

// *** bench/testbench.sv ***
// self-checking bench for the digital option module
module testbench
   import odio_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_clk = 1'b0, i_resetn = 1'b0, i_rd = 1'b0;
   odio_req_t   i_req = '0;
   odio_cond_t  cset = '0, i_cond;
   logic [3:0]  i_ac_in = 4'h0, o_fn_act;
   logic [1:0]  i_port_sel, o_port;
   logic [15:0] o_rdata, rd_val;
   logic        o_rvalid, inv;
   logic [7:0]  o_status, base;
   logic [2:0]  o_relay;
   int          failures = 0, n_compared = 0, j, c;
   integer      seed = 32'ha068;
   always #5 i_clk = ~i_clk;
   odio_host_model u_odio_host_model (.i_clk(i_clk), .i_set(cset), .o_cond(i_cond),
      .o_port_sel(i_port_sel));
   odio_top u_odio_top (.i_clk(i_clk), .i_resetn(i_resetn), .i_port_sel(i_port_sel),
      .i_req(i_req), .i_rd(i_rd), .i_cond(i_cond), .i_ac_in(i_ac_in), .o_rdata(o_rdata),
      .o_rvalid(o_rvalid), .o_status(o_status), .o_fn_act(o_fn_act), .o_relay(o_relay),
      .o_port(o_port));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge i_clk);
      #1 i_req = '{1'b1, a, d};
      @(posedge i_clk);
      #1 i_req.wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge i_clk);
      #1 i_req.addr = a;
      i_rd = 1'b1;
      @(posedge i_clk);
      #1 i_rd = 1'b0;
      check(16'(o_rvalid), 16'h0001);
      rd_val = o_rdata;
   endtask
   task automatic chk_defaults;
      for (int a = PARAM_IN1; a <= PARAM_MGMT; a++) begin
         rd(8'(a));
         check(rd_val, 16'h0000);
      end
   endtask
   // source condition picked by code s for relay r
   function automatic logic exp_src(input int s, input odio_cond_t cd, input int r);
      logic [12:0] v;
      v = {cd.fan, cd.network, cd.host_aux_control_word[r], cd.logic_out, cd.ext_brake,
           cd.ext_bypass, cd.alarm, cd.fault, cd.up_to_speed_condition, cd.running};
      return v[s];
   endfunction
   task automatic end_sim;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      #500_000;
      failures++;
      end_sim;
   end
   initial begin
      repeat (20) @(posedge i_clk);
      #1 i_resetn = 1'b1;
      chk_defaults();
      rd(8'h20);
      check(rd_val, 16'h0000);
      check(16'(o_port), 16'h0000);
      for (c = 0; c < 13; c++) begin
         j = {$random(seed)} % 4;
         wr(PARAM_IN1 + 8'(j), 16'(c));
         rd(PARAM_IN1 + 8'(j));
         check(rd_val, 16'(c));
      end
      wr(PARAM_IN1, 16'h0001);
      wr(PARAM_IN1, 16'h000d);
      rd(PARAM_IN1);
      check(rd_val, 16'h0001);
      wr(PARAM_STATUS, 16'h00fe);
      i_ac_in = 4'($random(seed)) | 4'h1;
      repeat (3) @(posedge i_clk);
      rd(PARAM_STATUS);
      check(16'(rd_val[4:0]), 16'({i_ac_in, 1'b1}));
      check(16'(o_fn_act[0]), 16'h0001);
      i_ac_in = 4'h0;
      wr(PARAM_RLY1 + 8'h02, 16'h0096);
      rd(PARAM_RLY1 + 8'h02);
      check(rd_val, 16'(DELAY_MAX));
      wr(PARAM_RLY1 + 8'h02, 16'h0000);
      for (c = 0; c < 39; c++) begin
         j = {$random(seed)} % 3;
         base = PARAM_RLY1 + 8'(4 * j);
         inv = 1'($random(seed));
         cset = odio_cond_t'(15'($random(seed)));
         wr(base, 16'(c % 13));
         wr(base + 8'h01, 16'(inv));
         wr(base, 16'h000d);
         repeat (6) @(posedge i_clk);
         #1 check(16'(o_relay[j]), 16'(exp_src(c % 13, cset, j) ^ inv));
         check(16'(o_status[7:5]), 16'(o_relay));
         rd(base);
         check(rd_val, 16'(c % 13));
      end
      cset = '0;
      wr(PARAM_RLY1, 16'(ODIO_SRC_HOST_AUX));
      wr(PARAM_RLY1 + 8'h01, 16'h0000);
      wr(PARAM_RLY1 + 8'h02, 16'h0001);
      wr(PARAM_RLY1 + 8'h04, 16'(ODIO_SRC_HOST_AUX));
      wr(PARAM_RLY1 + 8'h05, 16'h0000);
      cset.host_aux_control_word = 3'h3;
      repeat (100) @(posedge i_clk);
      #1 check(16'(o_relay[1:0]), 16'h0002);
      wr(PARAM_MGMT, 16'(MGMT_FACTORY));
      repeat (3) @(posedge i_clk);
      #1 check(16'(o_relay), 16'h0000);
      chk_defaults();
      // second reset in mid-run must clear settings and the status word while relay 3 is inverted on
      wr(PARAM_IN1 + 8'h03, 16'h0005);
      wr(PARAM_RLY1 + 8'h09, 16'h0001);
      @(posedge i_clk);
      #1 i_resetn = 1'b0;
      repeat (2) @(posedge i_clk);
      #1 i_resetn = 1'b1;
      check(16'(o_status), 16'h0000);
      chk_defaults();
      end_sim;
   end
endmodule

// *** rtl/odio_pkg.sv ***
// package of constants and types for the digital option port
package odio_pkg;
   localparam int unsigned CLK_HZ        = 100_000_000;
   localparam int unsigned TICK_MS       = 100;
   localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
   localparam logic [15:0] DELAY_MAX     = 16'h0064;
   localparam logic [15:0] DELAY_RESET   = 16'h0000;
   localparam logic [7:0]  PARAM_STATUS  = 8'h01;
   localparam logic [7:0]  PARAM_IN1     = 8'h02;
   localparam logic [7:0]  PARAM_IN4     = 8'h05;
   localparam logic [7:0]  PARAM_RLY1    = 8'h06;
   localparam logic [7:0]  PARAM_RLY3END = 8'h11;
   localparam logic [7:0]  PARAM_MGMT    = 8'h12;
   localparam int unsigned N_IN          = 4;
   localparam int unsigned N_RLY         = 3;
   localparam int unsigned ST_READY_BIT  = 0;
   localparam int unsigned ST_IN_LSB     = 1;
   localparam int unsigned ST_RLY_LSB    = 5;
   localparam logic [7:0]  FN_RESET      = 8'h00;
   localparam logic [7:0]  SRC_RESET     = 8'h00;
   localparam logic [7:0]  MGMT_READY    = 8'h00;
   localparam logic [7:0]  MGMT_FACTORY  = 8'h01;

   typedef enum logic [7:0] {
      ODIO_FN_DISABLE = 8'h00, ODIO_FN_START = 8'h01, ODIO_FN_COAST = 8'h02,
      ODIO_FN_STOP_OPT = 8'h03, ODIO_FN_START_COAST = 8'h04, ODIO_FN_START_STOP = 8'h05,
      ODIO_FN_DUAL_RAMP = 8'h06, ODIO_FN_OVERLOAD_PROFILE_SELECT = 8'h07,
      ODIO_FN_FAULT = 8'h08, ODIO_FN_FAULT_NC = 8'h09, ODIO_FN_CLEAR_FAULT = 8'h0a,
      ODIO_FN_EMERG_RUN = 8'h0b, ODIO_FN_MOTOR_HEATER = 8'h0c
   } odio_fn_t;

   typedef enum logic [7:0] {
      ODIO_SRC_NORMAL = 8'h00, ODIO_SRC_UP_TO_SPEED = 8'h01, ODIO_SRC_FAULT = 8'h02,
      ODIO_SRC_ALARM = 8'h03, ODIO_SRC_EXT_BYPASS = 8'h04, ODIO_SRC_EXT_BRAKE = 8'h05,
      ODIO_SRC_LOGIC = 8'h06, ODIO_SRC_HOST_AUX = 8'h07, ODIO_SRC_NET1 = 8'h08,
      ODIO_SRC_NET2 = 8'h09, ODIO_SRC_NET3 = 8'h0a, ODIO_SRC_NET4 = 8'h0b,
      ODIO_SRC_FAN = 8'h0c
   } odio_src_t;

   // host conditions that feed the relay source selectors
   typedef struct packed {
      logic       running;
      logic       up_to_speed_condition;
      logic       fault;
      logic       alarm;
      logic       ext_bypass;
      logic       ext_brake;
      logic       logic_out;
      logic [2:0] host_aux_control_word;
      logic [3:0] network;
      logic       fan;
   } odio_cond_t;

   typedef struct packed {
      logic        wr;
      logic [7:0]  addr;
      logic [15:0] wdata;
   } odio_req_t;

   typedef struct packed {
      logic [7:0]  src;
      logic        inv;
      logic [15:0] on_dly;
      logic [15:0] off_dly;
   } odio_rcfg_t;

   typedef enum logic [2:0] {
      ODIO_RS_OFF = 3'b001, ODIO_RS_ON_WAIT = 3'b010, ODIO_RS_ON = 3'b100
   } odio_rstate_t;

   typedef struct packed {
      odio_rstate_t st;
      logic [15:0]  cnt;
      logic         out;
   } odio_relay_state_t;
endpackage

// *** rtl/odio_relay.sv ***
// one auxiliary relay channel with on and off delays
module odio_relay
   import odio_pkg::*;
(
   input  wire logic        i_clk,     // system clock
   input  wire logic        i_resetn,  // async reset, active low
   input  wire logic        i_tick,    // 100 ms enable pulse
   input  wire logic        i_clr,     // factory restore, drop relay
   input  wire logic        i_want,    // source xor invert
   input  wire odio_rcfg_t  i_cfg,     // delays in 0.1 s
   output logic             o_out      // relay drive
);
   odio_relay_state_t s_reg, s_next;

   always_comb begin
      s_next = s_reg;
      case (s_reg.st)
         ODIO_RS_OFF: begin
            if (i_want) begin
               s_next.st  = ODIO_RS_ON_WAIT;
               s_next.cnt = 16'h0000;
               s_next.out = (i_cfg.on_dly == DELAY_RESET);
               if (i_cfg.on_dly == DELAY_RESET) s_next.st = ODIO_RS_ON;
            end
         end
         ODIO_RS_ON_WAIT: begin
            // counts up so a delay changed mid-wait still applies
            if (!i_want && !s_reg.out) begin
               s_next.st = ODIO_RS_OFF;
            end else if (!i_want) begin
               s_next.st = ODIO_RS_ON;
            end else if (i_tick) begin
               s_next.cnt = s_reg.cnt + 16'h0001;
               if (s_reg.cnt + 16'h0001 >= i_cfg.on_dly) begin
                  s_next.st  = ODIO_RS_ON;
                  s_next.out = 1'b1;
                  s_next.cnt = 16'h0000;
               end
            end
         end
         ODIO_RS_ON: begin
            if (i_want) begin
               s_next.cnt = 16'h0000;
            end else if (i_cfg.off_dly == DELAY_RESET) begin
               s_next.st  = ODIO_RS_OFF;
               s_next.out = 1'b0;
            end else if (i_tick) begin
               s_next.cnt = s_reg.cnt + 16'h0001;
               if (s_reg.cnt + 16'h0001 >= i_cfg.off_dly) begin
                  s_next.st  = ODIO_RS_OFF;
                  s_next.out = 1'b0;
                  s_next.cnt = 16'h0000;
               end
            end
         end
         default: s_next = '{st: ODIO_RS_OFF, cnt: 16'h0000, out: 1'b0};
      endcase
      if (i_clr) s_next = '{st: ODIO_RS_OFF, cnt: 16'h0000, out: 1'b0};
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) s_reg <= '{st: ODIO_RS_OFF, cnt: 16'h0000, out: 1'b0};
      else s_reg <= s_next;
   end

   assign o_out = s_reg.out;
endmodule

// *** rtl/odio_top.sv ***
// digital option module: four ac inputs, three delayed aux relays, parameter port
//
// Behaviour
// - The module sits on one of three option ports and holds its own parameter set there.
// - The module gives four line-voltage inputs and three auxiliary relay outputs.
// - Status bit 0 reads 1 when the module is ready and 0 when disabled.
// - Status bits 1 to 4 mirror the states of inputs 1 to 4.
// - Status bits 5 to 7 mirror the states of relays 1 to 3.
// - Each input has a selectable function from a fixed list, Disable after reset.
// - Each relay has a selectable source condition, Normal after reset.
// - Each relay has an invert setting, off after reset, that reverses its sense.
// - Each relay has on and off delays of 0.0 to 10.0 s, zero after reset.
// - A relay sourced from host output control follows its own bit of parameter 180.
// - Writing Factory Default to parameter management restores all defaults and reads Ready.
module odio_top
   import odio_pkg::*;
(
   input  wire logic        i_clk,      // system clock, 100 MHz
   input  wire logic        i_resetn,   // async reset, active low
   input  wire logic [1:0]  i_port_sel, // option port 07, 08 or 09 as 0..2
   input  wire odio_req_t   i_req,      // parameter access from host
   input  wire logic        i_rd,       // read strobe
   input  wire odio_cond_t  i_cond,     // host conditions for relay sources
   input  wire logic [3:0]  i_ac_in,    // line-voltage inputs, conditioned
   output logic [15:0]      o_rdata,    // read data, one cycle after strobe
   output logic             o_rvalid,   // read data valid pulse
   output logic [7:0]       o_status,   // status word copy
   output logic [3:0]       o_fn_act,   // inputs with a non-disabled function asserted
   output logic [2:0]       o_relay,    // relay coils
   output logic [1:0]       o_port      // port the parameter set is held on
);
   typedef struct packed {
      logic [N_IN-1:0][7:0]      fn;
      odio_rcfg_t [N_RLY-1:0]    rcfg;
      logic [7:0]                mgmt;
      logic [23:0]               tick_cnt;
      logic                      tick;
      logic                      ready;
      logic [3:0]                in_s;
      logic [15:0]               rdata;
      logic                      rvalid;
      logic [7:0]                status;
      logic [3:0]                fn_act;
      logic [2:0]                relay;
      logic [1:0]                port;
      logic                      restore;
   } odio_state_t;

   odio_state_t s_reg, s_next;
   logic [N_RLY-1:0] relay_raw;
   logic [N_RLY-1:0] want;

   // index of a relay parameter and its field: 4 params per relay
   function automatic logic [1:0] rly_idx(input logic [7:0] a);
      logic [7:0] d;
      d = a - PARAM_RLY1;
      return d[3:2];
   endfunction

   function automatic logic [1:0] rly_fld(input logic [7:0] a);
      logic [7:0] d;
      d = a - PARAM_RLY1;
      return d[1:0];
   endfunction

   function automatic logic src_level(input logic [7:0] src, input odio_cond_t c,
                                      input int unsigned k);
      logic v;
      v = 1'b0;
      case (src)
         ODIO_SRC_NORMAL:      v = c.running;
         ODIO_SRC_UP_TO_SPEED: v = c.up_to_speed_condition;
         ODIO_SRC_FAULT:       v = c.fault;
         ODIO_SRC_ALARM:       v = c.alarm;
         ODIO_SRC_EXT_BYPASS:  v = c.ext_bypass;
         ODIO_SRC_EXT_BRAKE:   v = c.ext_brake;
         ODIO_SRC_LOGIC:       v = c.logic_out;
         ODIO_SRC_HOST_AUX:    v = c.host_aux_control_word[k];
         ODIO_SRC_NET1:        v = c.network[0];
         ODIO_SRC_NET2:        v = c.network[1];
         ODIO_SRC_NET3:        v = c.network[2];
         ODIO_SRC_NET4:        v = c.network[3];
         ODIO_SRC_FAN:         v = c.fan;
         default:              v = 1'b0;
      endcase
      return v;
   endfunction

   genvar g;
   generate
      for (g = 0; g < N_RLY; g++) begin : g_rly
         assign want[g] = src_level(s_reg.rcfg[g].src, i_cond, g)
                          ^ s_reg.rcfg[g].inv;
         odio_relay u_relay (
            .i_clk    (i_clk),
            .i_resetn (i_resetn),
            .i_tick   (s_reg.tick),
            .i_clr    (s_reg.restore),
            .i_want   (want[g]),
            .i_cfg    (s_reg.rcfg[g]),
            .o_out    (relay_raw[g])
         );
      end
   endgenerate

   always_comb begin
      logic [1:0] ri;
      logic [1:0] rf;
      logic [7:0] st;
      logic [15:0] dv;
      s_next = s_reg;
      ri = rly_idx(i_req.addr);
      rf = rly_fld(i_req.addr);
      dv = (i_req.wdata > DELAY_MAX) ? DELAY_MAX : i_req.wdata;
      st = {relay_raw, s_reg.in_s, s_reg.ready};
      s_next.restore = 1'b0;
      s_next.rvalid  = 1'b0;
      s_next.ready   = 1'b1;
      s_next.port    = i_port_sel;
      s_next.in_s    = i_ac_in;
      // 100 ms time base for the relay delays
      s_next.tick = 1'b0;
      if (s_reg.tick_cnt == 24'(TICK_CYCLES - 1)) begin
         s_next.tick_cnt = 24'h00_0000;
         s_next.tick     = 1'b1;
      end else begin
         s_next.tick_cnt = s_reg.tick_cnt + 24'h00_0001;
      end
      // parameter writes; status is read only
      if (i_req.wr) begin
         if (i_req.addr >= PARAM_IN1 && i_req.addr <= PARAM_IN4) begin
            if (i_req.wdata[7:0] <= ODIO_FN_MOTOR_HEATER)
               s_next.fn[i_req.addr - PARAM_IN1] = i_req.wdata[7:0];
         end else if (i_req.addr >= PARAM_RLY1 && i_req.addr <= PARAM_RLY3END) begin
            case (rf)
               2'd0: if (i_req.wdata[7:0] <= ODIO_SRC_FAN)
                        s_next.rcfg[ri].src = i_req.wdata[7:0];
               2'd1: s_next.rcfg[ri].inv = i_req.wdata[0];
               2'd2: s_next.rcfg[ri].on_dly = dv;
               default: s_next.rcfg[ri].off_dly = dv;
            endcase
         end else if (i_req.addr == PARAM_MGMT && i_req.wdata[7:0] == MGMT_FACTORY) begin
            // restore acts at once, so the setting never reads other than Ready
            for (int i = 0; i < N_IN; i++) s_next.fn[i] = FN_RESET;
            for (int i = 0; i < N_RLY; i++)
               s_next.rcfg[i] = '{src: SRC_RESET, inv: 1'b0,
                                  on_dly: DELAY_RESET, off_dly: DELAY_RESET};
            s_next.mgmt    = MGMT_READY;
            s_next.restore = 1'b1;
         end
      end
      s_next.status = st;
      s_next.relay  = relay_raw;
      for (int i = 0; i < N_IN; i++)
         s_next.fn_act[i] = s_reg.in_s[i] && (s_reg.fn[i] != ODIO_FN_DISABLE);
      if (i_rd) begin
         s_next.rvalid = 1'b1;
         s_next.rdata  = 16'h0000;
         if (i_req.addr == PARAM_STATUS) begin
            s_next.rdata = {8'h00, st};
         end else if (i_req.addr >= PARAM_IN1 && i_req.addr <= PARAM_IN4) begin
            s_next.rdata = {8'h00, s_reg.fn[i_req.addr - PARAM_IN1]};
         end else if (i_req.addr >= PARAM_RLY1 && i_req.addr <= PARAM_RLY3END) begin
            case (rf)
               2'd0: s_next.rdata = {8'h00, s_reg.rcfg[ri].src};
               2'd1: s_next.rdata = {15'h0000, s_reg.rcfg[ri].inv};
               2'd2: s_next.rdata = s_reg.rcfg[ri].on_dly;
               default: s_next.rdata = s_reg.rcfg[ri].off_dly;
            endcase
         end else if (i_req.addr == PARAM_MGMT) begin
            s_next.rdata = {8'h00, s_reg.mgmt};
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign o_rdata  = s_reg.rdata;
   assign o_rvalid = s_reg.rvalid;
   assign o_status = s_reg.status;
   assign o_fn_act = s_reg.fn_act;
   assign o_relay  = s_reg.relay;
   assign o_port   = s_reg.port;
endmodule
